// ---- common/urc_pkg.sv ----
// Constants, register map and carrier types of the ultrasonic ranging controller.
// Assumes a single 10 MHz clock and Avalon-MM register access with 32-bit data.
//
// Behaviour
// (R1) Sixteen sensor channels, each with own trigger output and echo timing.
// (R2) Default mode fires active sensors one at a time in an endless loop.
// (R3) Sequential mode takes any echo on the firing sensor as its own echo.
// (R4) Cross-echo groups of four: one sensor transmits, all four group sensors time echo; the code times echo only on the active members of the group.
// (R5) Distance is half the flight time times the speed of sound, both modes.
// (R6) Each sensor has its own writable warning and alarm threshold.
// (R7) Any distance below its warning threshold lights warning lamp and switches warning relay.
// (R8) Any obstacle inside its alarm threshold drives separate alarm lamp and relay.
// (R9) Objects nearer than 0.2 m are reported as too near; valid range 0.2 to 3.3 m.
// (R10) No echo within range reports empty range instead of a distance.
// (R11) Distances of all sensors are readable by the host.
// (R12) Warning thresholds are one byte per sensor, in centimetres.
// (R13) Two-bit setting per group selects which sensor of the group transmits.
// (R14) Inactive sensors are never triggered and are skipped, shortening the cycle.
// (R15) Warning and alarm re-evaluated after each measurement; clear when no sensor inside.
package urc_pkg;
  localparam int NCH = 16;
  localparam int NGRP = 4;
  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int SOUND_CM_S = 34_300;
  // Cycles of round-trip flight per centimetre of distance, rounded to nearest
  localparam int CM_CYC = (2 * CLK_HZ + SOUND_CM_S / 2) / SOUND_CM_S;
  localparam int MIN_CM = 20;
  localparam int MAX_CM = 330;
  localparam int TRIG_US = 300;
  localparam int TRIG_CYC = TRIG_US * (CLK_HZ / 1_000_000);
  localparam int FIRE_GAP_MS = 20;
  localparam int GAP_CYC = FIRE_GAP_MS * (CLK_HZ / 1000);
  // ---------------------------------------------------------------------------
  // Register word indices (byte address = 4 * index)
  // ---------------------------------------------------------------------------
  localparam logic [6:0] REG_CTRL = 7'h00;
  localparam logic [6:0] REG_ACTIVE = 7'h01;
  localparam logic [6:0] REG_XCFG = 7'h02;
  localparam logic [6:0] REG_STATUS = 7'h03;
  localparam logic [2:0] BANK_WARN = 3'h1;
  localparam logic [2:0] BANK_ALARM = 3'h2;
  localparam logic [2:0] BANK_DIST = 3'h3;
  // Reset values and field positions
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam logic [15:0] ACTIVE_RST = 16'hFFFF;
  localparam logic [7:0] XCFG_RST = 8'h00;
  localparam logic [7:0] WARN_RST = 8'h64;
  localparam logic [7:0] ALARM_RST = 8'h1E;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_XE_LSB = 4;
  localparam int DIST_NEAR_BIT = 16;
  localparam int DIST_EMPTY_BIT = 17;
  localparam int DIST_VALID_BIT = 18;
  localparam int STAT_WARN_BIT = 0;
  localparam int STAT_ALARM_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;

  typedef struct packed {
    logic valid;
    logic empty;
    logic near;
    logic [8:0] cm;
  } urc_result_t;

  typedef enum {URC_IDLE, URC_SCAN, URC_TRIG, URC_LISTEN, URC_STORE, URC_GAP} urc_state_t;
endpackage

// ---- design/urc_top.sv ----
// Ultrasonic ranging controller: sequencer, echo timing, thresholds, register slave.
// Assumes echo inputs are asynchronous pins and an Avalon-MM master on mclk_i.
`timescale 1ns/1ps
module urc_top #(
  parameter int CM_CYC_P = urc_pkg::CM_CYC,
  parameter int TRIG_CYC_P = urc_pkg::TRIG_CYC,
  parameter int GAP_CYC_P = urc_pkg::GAP_CYC
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [8:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [15:0] echo_i,
  output logic [15:0] trig_o,
  output logic warn_lamp_o,
  output logic warn_relay_o,
  output logic alarm_lamp_o,
  output logic alarm_relay_o
);
  localparam int NCH = urc_pkg::NCH;

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [7:0] ctrl_reg, ctrl_next;
  logic [15:0] active_reg, active_next;
  logic [7:0] xcfg_reg, xcfg_next;
  logic [7:0] warn_thr_reg [NCH];
  logic [7:0] warn_thr_next [NCH];
  logic [7:0] alarm_thr_reg [NCH];
  logic [7:0] alarm_thr_next [NCH];
  logic wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;

  urc_pkg::urc_state_t state_reg, state_next;
  logic [3:0] slot_reg, slot_next;
  logic [17:0] tmr_reg, tmr_next;
  logic [11:0] pre_reg, pre_next;
  logic [8:0] cm_reg, cm_next;
  logic [15:0] tx_reg, tx_next;
  logic [15:0] lis_reg, lis_next;
  logic [15:0] got_reg, got_next;
  logic [8:0] cap_reg [NCH];
  logic [8:0] cap_next [NCH];
  urc_pkg::urc_result_t res_reg [NCH];
  urc_pkg::urc_result_t res_next [NCH];
  logic eval_reg, eval_next;
  logic warn_reg, warn_next;
  logic alarm_reg, alarm_next;

  logic [15:0] echo_s1_reg, echo_s2_reg, echo_s3_reg;
  logic [15:0] echo_rise;
  logic [15:0] warn_hit, alarm_hit;

  logic [6:0] widx;
  logic [31:0] bmask;
  logic wr_go, req_new;
  logic [1:0] grp;
  logic xe;

  assign widx = avs_address_i[8:2];
  assign bmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                  {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign wr_go = avs_write_i && !wait_reg;
  assign req_new = (avs_read_i || avs_write_i) && wait_reg;
  assign grp = slot_reg[3:2];
  assign xe = ctrl_reg[urc_pkg::CTRL_XE_LSB + 32'(grp)];

  // ---------------------------------------------------------------------------
  // Echo synchronisers
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      echo_s1_reg <= 16'h0000;
      echo_s2_reg <= 16'h0000;
      echo_s3_reg <= 16'h0000;
    end else begin
      echo_s1_reg <= echo_i;
      echo_s2_reg <= echo_s1_reg;
      echo_s3_reg <= echo_s2_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // Per-channel edge detect and threshold compare
  // ---------------------------------------------------------------------------
  generate
    for (genvar i = 0; i < NCH; i++) begin : g_ch
      assign echo_rise[i] = echo_s2_reg[i] && !echo_s3_reg[i];
      // Too-near counts as inside any threshold; empty never does
      assign warn_hit[i] = active_reg[i] && res_reg[i].valid && !res_reg[i].empty &&
                           (res_reg[i].near || (res_reg[i].cm < {1'b0, warn_thr_reg[i]})); // R7
      assign alarm_hit[i] = active_reg[i] && res_reg[i].valid && !res_reg[i].empty &&
                            (res_reg[i].near || (res_reg[i].cm < {1'b0, alarm_thr_reg[i]})); // R8
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Register slave: one wait state for every access
  // ---------------------------------------------------------------------------
  always_comb begin
    ctrl_next = ctrl_reg;
    active_next = active_reg;
    xcfg_next = xcfg_reg;
    warn_thr_next = warn_thr_reg;
    alarm_thr_next = alarm_thr_reg;
    wait_next = !req_new;
    rdata_next = rdata_reg;
    if (wr_go) begin
      case (widx)
        urc_pkg::REG_CTRL: ctrl_next = (ctrl_reg & ~bmask[7:0]) | (avs_writedata_i[7:0] & bmask[7:0]);
        urc_pkg::REG_ACTIVE: active_next = (active_reg & ~bmask[15:0]) | (avs_writedata_i[15:0] & bmask[15:0]);
        urc_pkg::REG_XCFG: xcfg_next = (xcfg_reg & ~bmask[7:0]) | (avs_writedata_i[7:0] & bmask[7:0]); // R13
        default: begin
          if (widx[6:4] == urc_pkg::BANK_WARN && avs_byteenable_i[0]) begin
            warn_thr_next[widx[3:0]] = avs_writedata_i[7:0]; // R6 R12
          end
          if (widx[6:4] == urc_pkg::BANK_ALARM && avs_byteenable_i[0]) begin
            alarm_thr_next[widx[3:0]] = avs_writedata_i[7:0]; // R6
          end
        end
      endcase
    end
    if (req_new) begin
      rdata_next = 32'h0000_0000;
      if (avs_read_i) begin
        case (widx)
          urc_pkg::REG_CTRL: rdata_next = {24'h000000, ctrl_reg};
          urc_pkg::REG_ACTIVE: rdata_next = {16'h0000, active_reg};
          urc_pkg::REG_XCFG: rdata_next = {24'h000000, xcfg_reg};
          urc_pkg::REG_STATUS: begin
            rdata_next[urc_pkg::STAT_WARN_BIT] = warn_reg;
            rdata_next[urc_pkg::STAT_ALARM_BIT] = alarm_reg;
            rdata_next[urc_pkg::STAT_BUSY_BIT] = (state_reg != urc_pkg::URC_IDLE);
          end
          default: begin
            case (widx[6:4])
              urc_pkg::BANK_WARN: rdata_next = {24'h000000, warn_thr_reg[widx[3:0]]};
              urc_pkg::BANK_ALARM: rdata_next = {24'h000000, alarm_thr_reg[widx[3:0]]};
              urc_pkg::BANK_DIST: begin
                rdata_next[8:0] = res_reg[widx[3:0]].cm; // R11
                rdata_next[urc_pkg::DIST_NEAR_BIT] = res_reg[widx[3:0]].near;
                rdata_next[urc_pkg::DIST_EMPTY_BIT] = res_reg[widx[3:0]].empty;
                rdata_next[urc_pkg::DIST_VALID_BIT] = res_reg[widx[3:0]].valid;
              end
              default: rdata_next = 32'h0000_0000;
            endcase
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_reg <= urc_pkg::CTRL_RST;
      active_reg <= urc_pkg::ACTIVE_RST;
      xcfg_reg <= urc_pkg::XCFG_RST;
      for (int i = 0; i < NCH; i++) begin
        warn_thr_reg[i] <= urc_pkg::WARN_RST;
        alarm_thr_reg[i] <= urc_pkg::ALARM_RST;
      end
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ctrl_reg <= ctrl_next;
      active_reg <= active_next;
      xcfg_reg <= xcfg_next;
      warn_thr_reg <= warn_thr_next;
      alarm_thr_reg <= alarm_thr_next;
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Measurement sequencer
  // ---------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    slot_next = slot_reg;
    tmr_next = tmr_reg;
    pre_next = pre_reg;
    cm_next = cm_reg;
    tx_next = tx_reg;
    lis_next = lis_reg;
    got_next = got_reg;
    cap_next = cap_reg;
    res_next = res_reg;
    eval_next = 1'b0;
    case (state_reg)
      urc_pkg::URC_IDLE: begin
        if (ctrl_reg[urc_pkg::CTRL_RUN_BIT]) begin
          state_next = urc_pkg::URC_SCAN;
        end
      end
      urc_pkg::URC_SCAN: begin
        if (!ctrl_reg[urc_pkg::CTRL_RUN_BIT]) begin
          state_next = urc_pkg::URC_IDLE;
        end else if (active_reg[slot_reg] && (!xe || slot_reg[1:0] == xcfg_reg[2 * grp +: 2])) begin // R4 R13 R14
          tx_next = 16'h0001 << slot_reg; // R2
          // Cross groups listen on all active members; otherwise only the firing sensor
          lis_next = xe ? (active_reg & (16'h000F << {slot_reg[3:2], 2'b00})) : (16'h0001 << slot_reg); // R3 R4
          tmr_next = 18'(TRIG_CYC_P - 1);
          state_next = urc_pkg::URC_TRIG;
        end else begin
          slot_next = slot_reg + 4'h1; // R14
        end
      end
      urc_pkg::URC_TRIG: begin
        if (tmr_reg == 18'h00000) begin
          tx_next = 16'h0000;
          pre_next = 12'h000;
          cm_next = 9'h000;
          got_next = 16'h0000;
          state_next = urc_pkg::URC_LISTEN;
        end else begin
          tmr_next = tmr_reg - 18'h00001;
        end
      end
      urc_pkg::URC_LISTEN: begin
        // Prescaler turns flight time straight into centimetres of range
        if (pre_reg == 12'(CM_CYC_P - 1)) begin // R5
          pre_next = 12'h000;
          cm_next = cm_reg + 9'h001;
        end else begin
          pre_next = pre_reg + 12'h001;
        end
        for (int i = 0; i < NCH; i++) begin
          if (lis_reg[i] && !got_reg[i] && echo_rise[i]) begin // R1 R3
            got_next[i] = 1'b1;
            cap_next[i] = cm_reg;
          end
        end
        if (cm_reg == 9'(urc_pkg::MAX_CM) || (got_reg | ~lis_reg) == 16'hFFFF) begin // R10
          state_next = urc_pkg::URC_STORE;
        end
      end
      urc_pkg::URC_STORE: begin
        for (int i = 0; i < NCH; i++) begin
          if (lis_reg[i]) begin
            res_next[i].valid = 1'b1;
            res_next[i].empty = !got_reg[i]; // R10
            res_next[i].near = got_reg[i] && (cap_reg[i] < 9'(urc_pkg::MIN_CM)); // R9
            res_next[i].cm = got_reg[i] ? cap_reg[i] : 9'h000;
          end
        end
        eval_next = 1'b1; // R15
        slot_next = slot_reg + 4'h1;
        tmr_next = 18'(GAP_CYC_P - 1);
        state_next = urc_pkg::URC_GAP;
      end
      urc_pkg::URC_GAP: begin
        if (tmr_reg == 18'h00000) begin
          state_next = urc_pkg::URC_SCAN;
        end else begin
          tmr_next = tmr_reg - 18'h00001;
        end
      end
      default: state_next = urc_pkg::URC_IDLE;
    endcase
  end

  // Outputs hold between measurements and move only on a fresh evaluation
  always_comb begin
    warn_next = eval_reg ? (|warn_hit) : warn_reg; // R7 R15
    alarm_next = eval_reg ? (|alarm_hit) : alarm_reg; // R8 R15
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= urc_pkg::URC_IDLE;
      slot_reg <= 4'h0;
      tmr_reg <= 18'h00000;
      pre_reg <= 12'h000;
      cm_reg <= 9'h000;
      tx_reg <= 16'h0000;
      lis_reg <= 16'h0000;
      got_reg <= 16'h0000;
      for (int i = 0; i < NCH; i++) begin
        cap_reg[i] <= 9'h000;
        res_reg[i] <= '0;
      end
      eval_reg <= 1'b0;
      warn_reg <= 1'b0;
      alarm_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      slot_reg <= slot_next;
      tmr_reg <= tmr_next;
      pre_reg <= pre_next;
      cm_reg <= cm_next;
      tx_reg <= tx_next;
      lis_reg <= lis_next;
      got_reg <= got_next;
      cap_reg <= cap_next;
      res_reg <= res_next;
      eval_reg <= eval_next;
      warn_reg <= warn_next;
      alarm_reg <= alarm_next;
    end
  end

  assign trig_o = tx_reg;
  assign warn_lamp_o = warn_reg;
  assign warn_relay_o = warn_reg;
  assign alarm_lamp_o = alarm_reg;
  assign alarm_relay_o = alarm_reg;
  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = wait_reg;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  // Mode and mask writes may land mid-measurement, so firing checks look at the launch edge only
  logic launch;
  assign launch = (state_reg == urc_pkg::URC_SCAN) && (state_next == urc_pkg::URC_TRIG);

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  a_trig_single: assert property ($onehot0(trig_o)) // R1
    else $error("more than one trigger driven");
  a_trig_active: assert property (launch |=> // R14
                                  (trig_o != 16'h0000 && (trig_o & $past(active_reg)) == trig_o))
    else $error("inactive sensor triggered");
  a_seq_listen: assert property ((launch && !xe) |=> (lis_reg == tx_reg && tx_reg != 16'h0000)) // R2
    else $error("sequential listener differs from transmitter");
  a_cross_tx: assert property ((launch && xe) |=> // R4
                               (tx_reg == (16'h0001 << {$past(grp), $past(xcfg_reg[2 * grp +: 2])}) &&
                                (lis_reg & tx_reg) == tx_reg))
    else $error("cross group fired the wrong sensor");
  a_echo_capture: assert property ( // R3
                                   (state_reg == urc_pkg::URC_LISTEN && lis_reg[0] && !got_reg[0] && echo_rise[0])
                                   |=> (got_reg[0] && cap_reg[0] == $past(cm_reg)))
    else $error("echo not captured at its range");
  a_result_kind: assert property ((state_reg == urc_pkg::URC_STORE && lis_reg[0]) |=> // R10
                                  (res_reg[0].empty == !$past(got_reg[0]) && !(res_reg[0].empty && res_reg[0].near)))
    else $error("empty and near flags wrong");
  a_range_valid: assert property ((res_reg[0].valid && !res_reg[0].empty && !res_reg[0].near) |-> // R9
                                  (res_reg[0].cm >= 9'(urc_pkg::MIN_CM) && res_reg[0].cm <= 9'(urc_pkg::MAX_CM)))
    else $error("reported distance outside range");
  a_cm_bound: assert property ((state_reg == urc_pkg::URC_LISTEN && cm_reg == 9'(urc_pkg::MAX_CM)) // R10
                               |=> (state_reg == urc_pkg::URC_STORE))
    else $error("listen window overran");
  a_warn_eval: assert property ($changed(warn_reg) || $changed(alarm_reg) |-> $past(eval_reg)) // R15
    else $error("indicator moved without evaluation");
  a_warn_set: assert property (eval_reg |=> (warn_lamp_o == $past(|warn_hit) && alarm_relay_o == $past(|alarm_hit))) // R7
    else $error("indicators do not follow threshold hits");
  a_bus_answer: assert property (req_new |=> (!avs_waitrequest_o ##1 avs_waitrequest_o))
    else $error("bus answer not one wait state");

  c_seq_meas: cover property (state_reg == urc_pkg::URC_STORE && !xe && got_reg[slot_reg]);
  c_cross_meas: cover property (state_reg == urc_pkg::URC_STORE && xe && ($countones(got_reg) > 1));
  c_empty: cover property (state_reg == urc_pkg::URC_STORE && got_reg == 16'h0000);
  c_alarm: cover property ($rose(alarm_reg));
endmodule // urc_top

// ---- test/urc_sensor_model.sv ----
// Behavioural model of sixteen ultrasonic transducers on the ranging controller's trigger and echo pins.
// Assumes the controller's clock; echo lines are driven by the sensors and idle low.
`timescale 1ns/1ps
module urc_sensor_model #(
  parameter int CM_CYC_P = 8
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [15:0] trig_i,
  input wire logic [8:0] obj_cm_i [16],
  input wire logic mates_i,
  output logic [15:0] echo_o
);
  int delay_cnt [16];
  int hold_cnt [16];
  logic [15:0] trig_prev;

  // ---------------------------------------------------------------------------
  // Flight time
  // ---------------------------------------------------------------------------
  // Echo lands mid-step of the centimetre count so sync latency cannot tip it.
  // A zero obstacle distance means nothing reflects: no echo at all.
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trig_prev <= 16'h0000;
      for (int j = 0; j < 16; j++) begin
        delay_cnt[j] <= 0;
        hold_cnt[j] <= 0;
      end
    end else begin
      trig_prev <= trig_i;
      for (int j = 0; j < 16; j++) begin
        if (delay_cnt[j] == 1)
          hold_cnt[j] <= 3;
        else if (hold_cnt[j] > 0)
          hold_cnt[j] <= hold_cnt[j] - 1;
        if (delay_cnt[j] > 0)
          delay_cnt[j] <= delay_cnt[j] - 1;
        for (int k = 0; k < 16; k++) begin
          // Neighbours in a group of four hear the pulse only when mates_i is set
          if (trig_prev[k] && !trig_i[k] && (k / 4 == j / 4) && (j == k || mates_i) &&
              obj_cm_i[j] != 9'h000)
            delay_cnt[j] <= int'(obj_cm_i[j]) * CM_CYC_P + CM_CYC_P / 2 - 3;
        end
      end
    end
  end

  always_comb begin
    for (int j = 0; j < 16; j++) begin
      echo_o[j] = hold_cnt[j] > 0;
    end
  end
endmodule // urc_sensor_model

// ---- test/test_ultrasonic_ranging_controller.sv ----
// Self-checking bench of the ultrasonic ranging controller: register bus tasks, sensor model, lamp checks.
// Assumes shortened counts; obstacle distances are set per channel in the sensor model.
`timescale 1ns/1ps
module test_ultrasonic_ranging_controller;
  localparam int CM_P = 8;
  localparam logic [31:0] DMASK = 32'h000701FF;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [8:0] addr = 9'h000;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] be = 4'hF;
  logic [31:0] rdata;
  logic waitreq;
  logic [15:0] echo;
  logic [15:0] trig;
  logic warn_lamp, warn_relay, alarm_lamp, alarm_relay;
  logic [8:0] obj_cm [16] = '{default: 9'h000};
  logic mates = 1'b0;
  logic [15:0] fired = 16'h0000;
  logic [31:0] rd;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;

  urc_top #(.CM_CYC_P(CM_P), .TRIG_CYC_P(4), .GAP_CYC_P(8)) i_urc_top (
    .mclk_i(mclk), .rstn_i(rstn), .avs_address_i(addr), .avs_read_i(rd_en), .avs_write_i(wr_en),
    .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .echo_i(echo), .trig_o(trig), .warn_lamp_o(warn_lamp), .warn_relay_o(warn_relay),
    .alarm_lamp_o(alarm_lamp), .alarm_relay_o(alarm_relay));

  urc_sensor_model #(.CM_CYC_P(CM_P)) i_urc_sensor_model (
    .mclk_i(mclk), .rstn_i(rstn), .trig_i(trig), .obj_cm_i(obj_cm), .mates_i(mates), .echo_o(echo));

  always #50 mclk = ~mclk;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic results();
    $display("Checks %0d, errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  // Trigger history and a hang guard; two triggers at once would fire into each other
  always @(posedge mclk) begin
    cyc++;
    fired |= trig;
    if ($countones(trig) > 1) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, trig, 16'h0000);
      err_count++;
    end
    if (cyc == 90000) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, cyc, 32'h00000000);
      err_count++;
      results();
    end
  end

  task automatic bus_write(input logic [8:0] a, input logic [31:0] d, input logic [3:0] lanes);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    be <= lanes;
    wr_en <= 1'b1;
    do @(posedge mclk); while (waitreq !== 1'b0);
    wr_en <= 1'b0;
  endtask

  task automatic bus_read(input logic [8:0] a);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    do @(posedge mclk); while (waitreq !== 1'b0);
    rd = rdata;
    rd_en <= 1'b0;
  endtask

  function automatic logic [31:0] dval(input logic [8:0] cm);
    return {23'h000000, cm} | (32'h00000001 << urc_pkg::DIST_VALID_BIT);
  endfunction

  // Re-reads a distance until it matches, so a full scan loop may pass meanwhile
  task automatic poll_dist(input int ch, input logic [31:0] exp, input logic [31:0] mask);
    int n;
    n = 0;
    do begin
      bus_read(9'h0C0 + 9'(4 * ch));
      n++;
    end while ((rd & mask) !== exp && n < 4000);
    chk(rd & mask, exp);
  endtask

  task automatic wait_lamps(input logic w, input logic a);
    int n;
    n = 0;
    while ({warn_lamp, alarm_lamp} !== {w, a} && n < 12000) begin
      @(posedge mclk);
      n++;
    end
    chk({28'h0000000, warn_relay, alarm_relay, warn_lamp, alarm_lamp}, {28'h0000000, w, a, w, a});
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    bus_read(9'h004);
    chk(rd, {16'h0000, urc_pkg::ACTIVE_RST});
    obj_cm[0] <= 9'h032;
    obj_cm[1] <= 9'h00A;
    bus_write(9'h004, 32'h00000007, 4'hF);
    fired = 16'h0000;
    bus_read(9'h000);
    chk(rd, {24'h000000, urc_pkg::CTRL_RST});
    for (int i = 0; i < 16; i++) begin
      bus_read(9'h040 + 9'(4 * i));
      chk(rd, {24'h000000, urc_pkg::WARN_RST});
      bus_read(9'h080 + 9'(4 * i));
      chk(rd, {24'h000000, urc_pkg::ALARM_RST});
    end
    bus_read(9'h008);
    chk(rd, 32'h00000000);
    bus_read(9'h100);
    chk(rd, 32'h00000000);
    // Threshold bytes sit in lane 0; a write without it must leave them alone
    bus_write(9'h040, 32'h00000028, 4'hE);
    bus_read(9'h040);
    chk(rd, {24'h000000, urc_pkg::WARN_RST});
    poll_dist(0, dval(9'h032), DMASK);
    poll_dist(1, 32'h00050000, 32'h00070000);
    poll_dist(2, 32'h00060000, DMASK);
    wait_lamps(1'b1, 1'b1);
    bus_read(9'h00C);
    chk(rd & 32'h00000007, 32'h00000007);
    bus_write(9'h0C0, 32'h000001FF, 4'hF);
    bus_read(9'h0C0);
    chk(rd & DMASK, dval(9'h032));
    obj_cm[1] <= 9'h096;
    poll_dist(1, dval(9'h096), DMASK);
    wait_lamps(1'b1, 1'b0);
    bus_write(9'h040, 32'h00000028, 4'hF);
    wait_lamps(1'b0, 1'b0);
    chk({16'h0000, fired}, 32'h00000007);
    obj_cm[0] <= 9'h019;
    wait_lamps(1'b1, 1'b1);
    // Cross-echo on group 1 with its third sensor as transmitter
    obj_cm[4] <= 9'h078;
    obj_cm[5] <= 9'h082;
    obj_cm[6] <= 9'h08C;
    obj_cm[7] <= 9'h096;
    // Mode set up before the group is switched on, so no group 1 pulse sees a half-set mode
    bus_write(9'h008, 32'h00000008, 4'hF);
    bus_write(9'h000, 32'h00000021, 4'hF);
    mates <= 1'b1;
    bus_write(9'h004, 32'h000000F0, 4'hF);
    bus_read(9'h008);
    chk(rd, 32'h00000008);
    poll_dist(7, dval(9'h096), DMASK);
    fired = 16'h0000;
    obj_cm[5] <= 9'h06E;
    poll_dist(5, dval(9'h06E), DMASK);
    poll_dist(4, dval(9'h078), DMASK);
    poll_dist(6, dval(9'h08C), DMASK);
    chk({16'h0000, fired}, 32'h00000040);
    wait_lamps(1'b0, 1'b0);
    results();
  end
endmodule // test_ultrasonic_ranging_controller
